// ### src/tc8_pkg.sv
// Package: register map, field layout and modes of the 8-bit timer/counter.
// Assumes a classic Wishbone slave with 32-bit data, byte addresses.
package tc8_pkg;

  // Register byte offsets
  localparam logic [7:0] ctrl_a_off = 8'h00;
  localparam logic [7:0] ctrl_b_off = 8'h04;
  localparam logic [7:0] count_off = 8'h08;
  localparam logic [7:0] cmp_a_off = 8'h0c;
  localparam logic [7:0] cmp_b_off = 8'h10;
  localparam logic [7:0] flag_off = 8'h14;
  localparam logic [7:0] mask_off = 8'h18;
  localparam logic [7:0] async_off = 8'h1c;

  // Field positions in control_reg_a
  localparam int wgm_lo_pos = 0;
  localparam int mode_b_pos = 4;
  localparam int mode_a_pos = 6;
  // Field positions in control_reg_b
  localparam int cs_pos = 0;
  localparam int wgm_hi_pos = 3;
  localparam int force_b_pos = 6;
  localparam int force_a_pos = 7;
  // Flag and mask bit positions
  localparam int ovf_pos = 0;
  localparam int cfa_pos = 1;
  localparam int cfb_pos = 2;
  // async_status_reg bit position
  localparam int as_pos = 5;

  localparam logic [7:0] bottom_val = 8'h00;
  localparam logic [7:0] max_val = 8'hff;
  localparam logic [7:0] reset_val = 8'h00;

  typedef enum logic [2:0] {
    wgm_normal = 3'b000,
    wgm_pc_max = 3'b001,
    wgm_ctc = 3'b010,
    wgm_fast_max = 3'b011,
    wgm_rsv4 = 3'b100,
    wgm_pc_cmp = 3'b101,
    wgm_rsv6 = 3'b110,
    wgm_fast_cmp = 3'b111
  } wgm_t;

  // Compare output modes
  localparam logic [1:0] com_off = 2'h0;
  localparam logic [1:0] com_toggle = 2'h1;
  localparam logic [1:0] com_clear = 2'h2;
  localparam logic [1:0] com_set = 2'h3;

  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [31:0] dat;
    logic [3:0] sel;
    logic cyc;
    logic stb;
  } wb_req_t;

endpackage : tc8_pkg

// ### src/timer8_counter_compare_unit.sv
// 8-bit timer/counter with two compare channels and a Wishbone slave.
// Assumes one clock; external timer clock pins arrive asynchronous.
`timescale 1ns/1ns
module timer8_counter_compare_unit
  import tc8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tc8_pkg::wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_pin_one_i,
  input wire logic ext_clk_i,
  input wire logic [2:0] irq_ack_i,
  output logic [2:0] irq_o,
  output logic compare_output_a_o,
  output logic compare_output_b_o,
  output logic [1:0] pin_override_o
);
  import tc8_pkg::*;

  // Registers; counter and compares 8 bits
  logic [7:0] ctrl_a_q, cs_q, wgm_hi_q, as_q;
  logic [7:0] counter_value_q, counter_value_d;
  logic [7:0] cmp_a_q, cmp_b_q, buf_a_q, buf_b_q;
  logic [2:0] flag_q, flag_d, mask_q;
  logic oc_a_q, oc_b_q, ack_q, block_q, up_q;
  logic [1:0] osc_sync_q, ext_sync_q;
  logic osc_prev_q, ext_prev_q;
  logic [31:0] rdat_q;

  // Bus decode
  wire logic req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  wire logic wr = req & wb_req_i.we & wb_req_i.sel[0];
  wire logic [7:0] wdat = wb_req_i.dat[7:0];
  wire logic wr_ctrl_a = wr && wb_req_i.adr == ctrl_a_off;
  wire logic wr_ctrl_b = wr && wb_req_i.adr == ctrl_b_off;
  wire logic wr_count = wr && wb_req_i.adr == count_off;
  wire logic wr_cmp_a = wr && wb_req_i.adr == cmp_a_off;
  wire logic wr_cmp_b = wr && wb_req_i.adr == cmp_b_off;
  wire logic wr_flag = wr && wb_req_i.adr == flag_off;
  wire logic wr_mask = wr && wb_req_i.adr == mask_off;
  wire logic wr_async = wr && wb_req_i.adr == async_off;

  // mode assembled from two control registers
  wire wgm_t wgm = wgm_t'({wgm_hi_q[0], ctrl_a_q[wgm_lo_pos +: 2]});
  wire logic [1:0] mode_a = ctrl_a_q[mode_a_pos +: 2];
  wire logic [1:0] mode_b = ctrl_a_q[mode_b_pos +: 2];

  function automatic logic is_pwm(input wgm_t m);
    is_pwm = !(m == wgm_normal || m == wgm_ctc);
  endfunction : is_pwm
  function automatic logic dual_slope(input wgm_t m);
    dual_slope = (m == wgm_pc_max || m == wgm_pc_cmp);
  endfunction : dual_slope
  function automatic logic apply_com(input logic [1:0] com,
                                     input logic cur);
    case (com)
      com_toggle: apply_com = ~cur;
      com_clear: apply_com = 1'b0;
      com_set: apply_com = 1'b1;
      default: apply_com = cur;
    endcase
  endfunction : apply_com

  wire logic at_bottom = counter_value_q == bottom_val;
  wire logic at_max = counter_value_q == max_val;
  wire logic top_is_a = wgm == wgm_pc_cmp || wgm == wgm_fast_cmp
                        || wgm == wgm_ctc;
  wire logic [7:0] top_val = top_is_a ? cmp_a_q : max_val;
  wire logic at_top = counter_value_q == top_val;

  // clock source select; zero stops the counter tick
  wire logic osc_rise = osc_sync_q[1] & ~osc_prev_q;
  wire logic ext_rise = ext_sync_q[1] & ~ext_prev_q;
  wire logic ext_fall = ~ext_sync_q[1] & ext_prev_q;
  logic src_tick;
  always_comb begin
    case (cs_q[2:0])
      3'h0: src_tick = 1'b0;
      3'h6: src_tick = ext_fall;
      3'h7: src_tick = ext_rise;
      default: src_tick = 1'b1;
    endcase
  end
  wire logic tick = src_tick && (as_q[as_pos] ? osc_rise : 1'b1);

  // matches, blocked one tick after a counter write
  wire logic match_a = tick && !block_q && counter_value_q == cmp_a_q;
  wire logic match_b = tick && !block_q && counter_value_q == cmp_b_q;

  logic up_d, ovf_set;
  always_comb begin
    counter_value_d = counter_value_q;
    up_d = up_q;
    ovf_set = 1'b0;
    if (tick) begin
      if (dual_slope(wgm)) begin
        if (at_top && up_q) begin
          up_d = 1'b0;
        end else if (at_bottom && !up_q) begin
          up_d = 1'b1;
          ovf_set = 1'b1;
        end
        counter_value_d = up_d ? counter_value_q + 8'h01
                               : counter_value_q - 8'h01;
      end else if (at_top && wgm != wgm_normal) begin
        counter_value_d = bottom_val;
        ovf_set = is_pwm(wgm) || at_max;
      end else begin
        // wrap from max, overflow as count becomes zero
        counter_value_d = counter_value_q + 8'h01;
        ovf_set = at_max;
      end
    end
    if (wr_count) begin
      counter_value_d = wdat;
    end
  end

  always_comb begin
    flag_d = flag_q & ~irq_ack_i;
    if (wr_flag) begin
      flag_d = flag_d & ~wdat[2:0];
    end
    flag_d[ovf_pos] = flag_d[ovf_pos] | ovf_set;
    flag_d[cfa_pos] = flag_d[cfa_pos] | match_a;
    flag_d[cfb_pos] = flag_d[cfb_pos] | match_b;
  end

  // buffered load at top (single slope) or at top while counting up (dual)
  wire logic dbuf = is_pwm(wgm);
  wire logic load_buf = dbuf && tick &&
                        (dual_slope(wgm) ? (at_top && up_q) : at_top);

  wire logic force_a = wr_ctrl_b && wdat[force_a_pos] && !dbuf;
  wire logic force_b = wr_ctrl_b && wdat[force_b_pos] && !dbuf;

  // output state update, mode bits live
  logic oc_a_d, oc_b_d;
  always_comb begin
    oc_a_d = oc_a_q;
    oc_b_d = oc_b_q;
    if (match_a || force_a) begin
      oc_a_d = apply_com(mode_a, oc_a_q);
    end
    if (match_b || force_b) begin
      oc_b_d = apply_com(mode_b, oc_b_q);
    end
  end

  // Read mux; buffer visible when double buffered
  logic [7:0] rd;
  always_comb begin
    case (wb_req_i.adr)
      ctrl_a_off: rd = ctrl_a_q;
      ctrl_b_off: rd = {2'b00, wgm_hi_q[0], cs_q[2:0]} & 8'h0f;
      count_off: rd = counter_value_q;
      cmp_a_off: rd = dbuf ? buf_a_q : cmp_a_q;
      cmp_b_off: rd = dbuf ? buf_b_q : cmp_b_q;
      flag_off: rd = {5'h00, flag_q};
      mask_off: rd = {5'h00, mask_q};
      async_off: rd = as_q;
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_q <= reset_val;
      cs_q <= reset_val;
      wgm_hi_q <= reset_val;
      as_q <= reset_val;
      mask_q <= 3'h0;
      flag_q <= 3'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req;
      rdat_q <= {24'h0, rd};
      flag_q <= flag_d;
      if (wr_ctrl_a) ctrl_a_q <= wdat & 8'hf3;
      if (wr_ctrl_b) cs_q <= {5'h00, wdat[cs_pos +: 3]};
      if (wr_ctrl_b) wgm_hi_q <= {7'h00, wdat[wgm_hi_pos]};
      if (wr_mask) mask_q <= wdat[2:0];
      if (wr_async) as_q <= wdat & 8'h20;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_value_q <= reset_val;
      up_q <= 1'b1;
      block_q <= 1'b0;
      oc_a_q <= 1'b0;
      oc_b_q <= 1'b0;
    end else begin
      counter_value_q <= counter_value_d;
      up_q <= up_d;
      oc_a_q <= oc_a_d;
      oc_b_q <= oc_b_d;
      // hold block until the next tick consumes it
      if (wr_count) block_q <= 1'b1;
      else if (tick) block_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_a_q <= reset_val;
      cmp_b_q <= reset_val;
      buf_a_q <= reset_val;
      buf_b_q <= reset_val;
    end else begin
      if (wr_cmp_a) buf_a_q <= wdat;
      if (wr_cmp_b) buf_b_q <= wdat;
      if (wr_cmp_a && !dbuf) cmp_a_q <= wdat;
      else if (load_buf) cmp_a_q <= buf_a_q;
      if (wr_cmp_b && !dbuf) cmp_b_q <= wdat;
      else if (load_buf) cmp_b_q <= buf_b_q;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_sync_q <= 2'b00;
      ext_sync_q <= 2'b00;
      osc_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[0], osc_pin_one_i};
      ext_sync_q <= {ext_sync_q[0], ext_clk_i};
      osc_prev_q <= osc_sync_q[1];
      ext_prev_q <= ext_sync_q[1];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  // each request gated by its mask bit
  assign irq_o = flag_q & mask_q;
  assign compare_output_a_o = oc_a_q;
  assign compare_output_b_o = oc_b_q;
  assign pin_override_o = {mode_a != com_off, mode_b != com_off};

  chk_read_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  chk_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_q[2:0] == 3'h0 && !wr_count) |=> $stable(counter_value_q))
    else $error("counter moved while stopped");
  chk_write_prio: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_count |=> counter_value_q == $past(wdat))
    else $error("counter write lost");
  chk_wrap_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && wgm == wgm_normal && at_max && !wr_count)
    |=> counter_value_q == 8'h00 && flag_q[ovf_pos])
    else $error("normal wrap wrong");
  chk_block_match: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_count ##1 (!tick)[*1] ##1 tick) |-> !match_a)
    else $error("blocked match flagged");
  chk_match_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    match_a |=> flag_q[cfa_pos]) else $error("compare flag not set");
  chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o[cfb_pos] |-> mask_q[cfb_pos] && flag_q[cfb_pos])
    else $error("ungated interrupt");
  chk_ctc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && wgm == wgm_ctc && at_top && !wr_count) |=> counter_value_q == 0)
    else $error("clear on match failed");
  chk_force_noflag: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (force_a && !match_a && !flag_q[cfa_pos]) |=> !flag_q[cfa_pos])
    else $error("force set flag");

  chk_ovf_flag: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ovf_set |=> flag_q[ovf_pos])
    else $error("overflow flag not set");

  chk_match_flag_b: assert property (@(posedge clk_i)
    disable iff (rst_i)
    match_b |=> flag_q[cfb_pos])
    else $error("compare flag b not set");

  chk_svc_clear: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (irq_ack_i[cfb_pos] && !match_b) |=> !flag_q[cfb_pos])
    else $error("serviced flag not cleared");

  chk_buf_hold: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (dbuf && !load_buf) |=> $stable(cmp_a_q))
    else $error("buffered compare moved off top");

  chk_direct_write: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wr_cmp_b && !dbuf) |=> cmp_b_q == $past(wdat))
    else $error("direct compare write lost");

  chk_force_out: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (force_b && !match_b && mode_b == com_set) |=> compare_output_b_o)
    else $error("force did not set output");

  chk_mode_keep: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wr_ctrl_a && !match_a && !force_a) |=> $stable(oc_a_q))
    else $error("output state lost on mode change");

  chk_normal_step: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (tick && wgm == wgm_normal && !wr_count)
    |=> counter_value_q == $past(counter_value_q) + 8'h01)
    else $error("normal mode did not count up");

  chk_fast_wrap: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (tick && wgm == wgm_fast_max && at_max && !wr_count)
    |=> counter_value_q == bottom_val)
    else $error("fast mode did not restart");

  chk_top_cmp: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (tick && wgm == wgm_fast_cmp && at_top && !wr_count)
    |=> counter_value_q == bottom_val)
    else $error("compare top not honoured");

  chk_bottom_turn: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (tick && dual_slope(wgm) && at_bottom && !up_q && !wr_count) |=> up_q)
    else $error("no turn at bottom");

  chk_osc_gate: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (as_q[as_pos] && !osc_rise) |-> !tick)
    else $error("tick without oscillator edge");

  chk_read_upper: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");

  chk_mask_ovf: assert property (@(posedge clk_i)
    disable iff (rst_i)
    irq_o[ovf_pos] |-> mask_q[ovf_pos] && flag_q[ovf_pos])
    else $error("ungated overflow request");

endmodule : timer8_counter_compare_unit

// ### tb/timer8_counter_compare_unit_tb.sv
// Self-checking bench for the 8-bit timer/counter with compare channels.
// Assumes the package offsets, byte lane 0 and a one-cycle bus answer.
`timescale 1ns/1ns
module timer8_counter_compare_unit_tb;
  import tc8_pkg::*;
`define CHECK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t req = '0;
  logic [31:0] rdat;
  logic ack;
  logic [2:0] irq_ack = 3'h0;
  logic [2:0] irq;
  logic osc = 1'b0;
  logic ext = 1'b0;
  logic oa;
  logic ob;
  logic [1:0] ovr;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'h8600bb0a;
  logic [7:0] rv;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];

  always #2 clk_i = ~clk_i;

  timer8_counter_compare_unit timer8_counter_compare_unit_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .osc_pin_one_i(osc), .ext_clk_i(ext),
    .irq_ack_i(irq_ack), .irq_o(irq), .compare_output_a_o(oa),
    .compare_output_b_o(ob), .pin_override_o(ovr));

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Request held until ack is seen at a rising edge
  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [7:0] d, input logic [7:0] e,
                    input logic [7:0] m);
    int n;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk_i);
    req <= '{adr: a, we: we, dat: {24'h0, d}, sel: 4'h1,
             cyc: 1'b1, stb: 1'b1};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) err_count++;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, d, 8'h00, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    wb(a, 1'b0, 8'h00, e, m);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // Edges slow enough for the pin synchronisers
  task automatic pulses(input bit use_osc, input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge clk_i);
      if (use_osc) osc <= 1'b1; else ext <= 1'b1;
      idle(6);
      if (use_osc) osc <= 1'b0; else ext <= 1'b0;
      idle(6);
    end
  endtask : pulses

  // Writes carry a zero mask; only masked read data is compared
  always @(posedge clk_i) begin
    logic [7:0] e;
    logic [7:0] m;
    if (ack === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 8'h00) `CHECK(rdat[7:0] & m, e & m)
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    idle(12);
    rst_i <= 1'b0;
    for (int a = 0; a <= 8'h20; a += 4) rd(8'(a), 8'h00, 8'hff);
    rv = 8'($random(seed));
    wr(cmp_a_off, rv);
    rd(cmp_a_off, rv, 8'hff);
    rv = 8'($random(seed));
    wr(count_off, rv);
    idle(5);
    rd(count_off, rv, 8'hff);
    wr(cmp_a_off, 8'h40);
    wr(cmp_b_off, 8'h40);
    // Start from zero so no match is passed before the blocking write
    wr(count_off, 8'h00);
    wr(ctrl_b_off, 8'h01);
    wr(count_off, 8'h40);
    wr(ctrl_b_off, 8'h00);
    rd(flag_off, 8'h00, 8'h06);
    wr(cmp_a_off, 8'hf8);
    // start value kept away from compare
    wr(count_off, 8'hf0);
    wr(ctrl_b_off, 8'h01);
    idle(40);
    wr(ctrl_b_off, 8'h00);
    rd(flag_off, 8'h03, 8'h07);
    rd(count_off, 8'h00, 8'hc0);
    wr(mask_off, 8'h01);
    idle(2);
    `CHECK(irq, 3'b001)
    @(posedge clk_i) irq_ack <= 3'b001;
    @(posedge clk_i) irq_ack <= 3'b000;
    idle(2);
    `CHECK(irq, 3'b000)
    wr(flag_off, 8'h02);
    rd(flag_off, 8'h00, 8'h07);
    wr(count_off, 8'h00);
    wr(cmp_a_off, 8'h03);
    wr(ctrl_a_off, 8'h02);
    wr(ctrl_b_off, 8'h01);
    idle(30);
    wr(ctrl_b_off, 8'h00);
    rd(count_off, 8'h00, 8'hfc);
    wr(flag_off, 8'h07);
    // output preset by force in normal mode
    wr(ctrl_a_off, 8'h40);
    wr(ctrl_b_off, 8'h80);
    idle(3);
    `CHECK(oa, 1'b1)
    `CHECK(ovr, 2'b10)
    rd(flag_off, 8'h00, 8'h02);
    wr(ctrl_a_off, 8'h00);
    wr(ctrl_b_off, 8'h80);
    idle(3);
    `CHECK(oa, 1'b1)
    wr(ctrl_a_off, 8'h43);
    idle(3);
    `CHECK(oa, 1'b1)
    wr(ctrl_a_off, 8'h00);
    wr(count_off, 8'h00);
    wr(ctrl_b_off, 8'h07);
    pulses(1'b0, 5);
    idle(8);
    wr(ctrl_b_off, 8'h00);
    rd(count_off, 8'h05, 8'hff);
    wr(async_off, 8'h20);
    wr(count_off, 8'h00);
    wr(ctrl_b_off, 8'h01);
    pulses(1'b1, 3);
    idle(8);
    wr(ctrl_b_off, 8'h00);
    wr(async_off, 8'h00);
    rd(count_off, 8'h03, 8'hff);
    idle(4);
    give_verdict();
  end
endmodule : timer8_counter_compare_unit_tb
